// ### logic/ssp_pkg.sv
`default_nettype none

package ssp_pkg;

    // APB address width and register indices (byte address is four times the index)
    localparam int         APB_AW        = 8;
    localparam logic [5:0] IDX_LEFT_ONE  = 6'h06;
    localparam logic [5:0] IDX_RIGHT_ONE = 6'h07;
    localparam logic [5:0] IDX_LEFT_TWO  = 6'h08;

    // Values after reset
    localparam logic [7:0] RST_LEFT_ONE  = 8'h01;
    localparam logic [7:0] RST_RIGHT_ONE = 8'h20;
    localparam logic [7:0] RST_LEFT_TWO  = 8'h32;
    localparam logic [1:0] RST_INSZ_LEFT_ONE  = 2'h0;
    localparam logic [1:0] RST_INSZ_RIGHT_ONE = 2'h2;
    localparam logic [1:0] RST_INSZ_LEFT_TWO  = 2'h3;
    localparam logic [2:0] RST_SNS_LEFT_ONE   = 3'h1;
    localparam logic [2:0] RST_SNS_RIGHT_ONE  = 3'h0;
    localparam logic [2:0] RST_SNS_LEFT_TWO   = 3'h2;

    // Field positions
    localparam int INSZ_LSB      = 4;
    localparam int SNS_LSB       = 0;
    localparam int INSZ_SKIP_BIT = 1;
    localparam int MARKER_BIT    = 7;

    // Input-size codes
    localparam logic [1:0] INSZ_24 = 2'h0;
    localparam logic [1:0] INSZ_16 = 2'h1;

    // Sense-output codes
    localparam logic [2:0] SNS_VOLT   = 3'h0;
    localparam logic [2:0] SNS_CURR   = 3'h1;
    localparam logic [2:0] SNS_BATT   = 3'h2;
    localparam logic [2:0] SNS_CTRL   = 3'h3;
    localparam logic [2:0] SNS_ALT    = 3'h4;
    localparam logic [2:0] SNS_STATUS = 3'h5;
    localparam logic [2:0] SNS_MARKER = 3'h6;
    localparam logic [2:0] SNS_BLANK  = 3'h7;

    // Placement lengths in bit clocks
    localparam logic [4:0] LEN_24 = 5'h18;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [4:0] LEN_8  = 5'h08;

    // Placements handled here; index value N_PLACE means idle or handed on
    localparam int         N_PLACE    = 3;
    localparam logic [1:0] PLACE_IDLE = 2'h3;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [7:0]  battery;
        logic [7:0]  control;
        logic [7:0]  status;
        logic [2:0]  slot_id;
    } ssp_sense_t;

    typedef struct packed {
        logic [23:0] word;
        logic [1:0]  placement;
    } ssp_audio_t;

endpackage

`default_nettype wire

// ### logic/ssp_walk.sv
`default_nettype none

module ssp_walk
    import ssp_pkg::*;
#(
    parameter int NP = N_PLACE
)
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            tick,
    input  wire logic            start,
    input  wire logic [NP*5-1:0] lens,
    output logic      [1:0]      place,
    output logic      [4:0]      cnt,
    output logic                 last,
    output logic                 busy
);

    logic [1:0] place_reg;
    logic [4:0] cnt_reg;
    logic [4:0] len_cur;

    // Position of the bit taken on this tick
    assign place   = start ? 2'h0 : place_reg;
    assign cnt     = start ? 5'h00 : cnt_reg;
    assign busy    = place != PLACE_IDLE;
    assign len_cur = busy ? lens[5*int'(place) +: 5] : LEN_8;
    assign last    = busy && (cnt == 5'(len_cur - 5'h01));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            place_reg <= PLACE_IDLE;
            cnt_reg   <= 5'h00;
        end
        else if (tick && busy)
        begin
            place_reg <= last ? 2'(place + 2'h1) : place;
            cnt_reg   <= last ? 5'h00 : 5'(cnt + 5'h01);
        end
    end

endmodule

`default_nettype wire

// ### logic/ssp_ctrl.sv
`default_nettype none

module ssp_ctrl
    import ssp_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              bclk_pin,
    input  wire logic              fsync_pin,
    input  wire logic              sdata_in_pin,
    output logic                   sdata_out_pin,
    output logic                   sdata_out_oe,
    input  wire ssp_sense_t        sense_in,
    output ssp_audio_t             audio_out,
    output logic                   audio_valid,
    output logic                   audio_defer
);

    logic [7:0]  cfg_reg [N_PLACE];
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        bclk_s1_reg, bclk_s2_reg, bclk_s3_reg;
    logic        fs_s1_reg, fs_s2_reg, fs_prev_reg;
    logic        sd_s1_reg, sd_s2_reg;
    logic        out_pending_reg;
    logic        alt_reg;
    ssp_sense_t  snap_reg;
    logic [23:0] shift_reg;
    ssp_audio_t  audio_reg;
    logic        audio_valid_reg;
    logic        audio_defer_reg;
    logic        sdo_reg;
    logic        sdo_oe_reg;
    logic        first_reg;

    // Register decode
    logic [5:0]  reg_idx;
    logic [2:0]  hit;
    logic        addr_ok;
    logic [1:0]  sel;
    logic        access;
    logic        wr_en;
    logic [7:0]  rd_byte;

    assign reg_idx = paddr[7:2];
    assign hit[0]  = reg_idx == IDX_LEFT_ONE;
    assign hit[1]  = reg_idx == IDX_RIGHT_ONE;
    assign hit[2]  = reg_idx == IDX_LEFT_TWO;
    assign addr_ok = (paddr[1:0] == 2'h0) && (|hit);
    assign sel     = hit[2] ? 2'h2 : (hit[1] ? 2'h1 : 2'h0);
    assign access  = psel && penable;
    assign wr_en   = access && pready_reg && pwrite && addr_ok;
    assign rd_byte = addr_ok ? cfg_reg[sel] : 8'h00;

    // Per-placement field decode
    logic [1:0]         insz   [N_PLACE];
    logic [2:0]         sns    [N_PLACE];
    logic [N_PLACE-1:0] skip;
    logic [N_PLACE*5-1:0] in_lens;
    logic [N_PLACE*5-1:0] out_lens;

    genvar gi;
    generate
        for (gi = 0; gi < N_PLACE; gi++)
        begin : g_field
            assign insz[gi] = cfg_reg[gi][INSZ_LSB +: 2];
            assign sns[gi]  = cfg_reg[gi][SNS_LSB +: 3];
            assign skip[gi] = insz[gi][INSZ_SKIP_BIT];
            assign in_lens[5*gi +: 5] = skip[gi] ? LEN_8 :
                                        (insz[gi] == INSZ_16 ? LEN_16 : LEN_24);
            assign out_lens[5*gi +: 5] = (sns[gi] == SNS_VOLT || sns[gi] == SNS_CURR ||
                                          sns[gi] == SNS_ALT) ? LEN_16 : LEN_8;
        end
    endgenerate

    // Audio comes from the first placement that does not skip
    logic [1:0] aud_sel;
    assign aud_sel = !skip[0] ? 2'h0 :
                     !skip[1] ? 2'h1 :
                     !skip[2] ? 2'h2 : PLACE_IDLE;

    // Bit clock edges from the synchronised pin
    logic rise_tick;
    logic fall_tick;
    logic frame_start;

    assign rise_tick   = bclk_s2_reg && !bclk_s3_reg;
    assign fall_tick   = !bclk_s2_reg && bclk_s3_reg;
    assign frame_start = rise_tick && fs_s2_reg && !fs_prev_reg;

    // Input and output walkers
    logic [1:0] in_place, out_place;
    logic [4:0] in_cnt, out_cnt;
    logic       in_last, out_last;
    logic       in_busy, out_busy;
    logic       out_start;

    assign out_start = fall_tick && out_pending_reg;

    ssp_walk #(
        .NP (N_PLACE)
    ) u_in_walk (
        .clk   (pclk),
        .rst_n (presetn),
        .tick  (rise_tick),
        .start (frame_start),
        .lens  (in_lens),
        .place (in_place),
        .cnt   (in_cnt),
        .last  (in_last),
        .busy  (in_busy)
    );

    ssp_walk #(
        .NP (N_PLACE)
    ) u_out_walk (
        .clk   (pclk),
        .rst_n (presetn),
        .tick  (fall_tick),
        .start (out_start),
        .lens  (out_lens),
        .place (out_place),
        .cnt   (out_cnt),
        .last  (out_last),
        .busy  (out_busy)
    );

    // Audio capture
    logic        cap_bit;
    logic [23:0] shift_next;
    logic [23:0] word_next;

    assign cap_bit    = rise_tick && in_busy && (in_place == aud_sel);
    assign shift_next = {shift_reg[22:0], sd_s2_reg};
    assign word_next  = (insz[aud_sel] == INSZ_16) ? {shift_next[15:0], 8'h00} : shift_next;

    // Sense word for the current output placement, left aligned
    logic [2:0]  out_code;
    logic [15:0] sense_word;
    logic        alt_phase;
    logic        out_bit;

    assign out_code  = out_busy ? sns[out_place] : SNS_BLANK;
    assign alt_phase = out_start ? !alt_reg : alt_reg;
    always_comb
    begin
        sense_word = 16'h0000;
        unique case (out_code)
            SNS_VOLT:   sense_word = snap_reg.voltage;
            SNS_CURR:   sense_word = snap_reg.current;
            SNS_ALT:    sense_word = alt_phase ? snap_reg.current : snap_reg.voltage;
            SNS_BATT:   sense_word = {snap_reg.battery, 8'h00};
            SNS_CTRL:   sense_word = {snap_reg.control, 8'h00};
            SNS_STATUS: sense_word = {snap_reg.status, 8'h00};
            SNS_MARKER: sense_word = {alt_phase, 4'h0, snap_reg.slot_id, 8'h00};
            SNS_BLANK:  sense_word = 16'h0000;
        endcase
    end
    assign out_bit = sense_word[4'(4'hf - out_cnt[3:0])];

    // APB slave, one wait state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            pready_reg  <= access && !pready_reg;
            pslverr_reg <= access && !pready_reg && !addr_ok;
            prdata_reg  <= (access && !pready_reg && !pwrite) ? {24'h000000, rd_byte} : 32'h0;
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_reg[0] <= RST_LEFT_ONE;
            cfg_reg[1] <= RST_RIGHT_ONE;
            cfg_reg[2] <= RST_LEFT_TWO;
        end
        else if (wr_en)
        begin
            cfg_reg[sel] <= pwdata[7:0];
        end
    end

    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bclk_s1_reg <= 1'b0;
            bclk_s2_reg <= 1'b0;
            bclk_s3_reg <= 1'b0;
            fs_s1_reg   <= 1'b0;
            fs_s2_reg   <= 1'b0;
            sd_s1_reg   <= 1'b0;
            sd_s2_reg   <= 1'b0;
        end
        else
        begin
            bclk_s1_reg <= bclk_pin;
            bclk_s2_reg <= bclk_s1_reg;
            bclk_s3_reg <= bclk_s2_reg;
            fs_s1_reg   <= fsync_pin;
            fs_s2_reg   <= fs_s1_reg;
            sd_s1_reg   <= sdata_in_pin;
            sd_s2_reg   <= sd_s1_reg;
        end
    end

    // Frame tracking and sense snapshot
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fs_prev_reg     <= 1'b0;
            out_pending_reg <= 1'b0;
            alt_reg         <= 1'b0;
            snap_reg        <= '0;
            first_reg       <= 1'b1;
        end
        else
        begin
            first_reg <= 1'b0;
            if (rise_tick)
            begin
                fs_prev_reg <= fs_s2_reg;
            end
            if (frame_start)
            begin
                out_pending_reg <= 1'b1;
                snap_reg        <= sense_in;
            end
            else if (out_start)
            begin
                out_pending_reg <= 1'b0;
            end
            if (out_start)
            begin
                alt_reg <= !alt_reg;
            end
        end
    end

    // Audio word assembly
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_reg       <= 24'h000000;
            audio_reg       <= '0;
            audio_valid_reg <= 1'b0;
            audio_defer_reg <= 1'b0;
        end
        else
        begin
            audio_valid_reg <= cap_bit && in_last;
            audio_defer_reg <= frame_start && (aud_sel == PLACE_IDLE);
            if (cap_bit)
            begin
                shift_reg <= shift_next;
            end
            if (cap_bit && in_last)
            begin
                audio_reg.word      <= word_next;
                audio_reg.placement <= in_place;
            end
        end
    end

    // Sense output pin, updated on falling bit clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sdo_reg    <= 1'b0;
            sdo_oe_reg <= 1'b0;
        end
        else if (fall_tick)
        begin
            sdo_reg    <= out_busy ? out_bit : 1'b0;
            sdo_oe_reg <= out_busy;
        end
    end

    assign prdata        = prdata_reg;
    assign pready        = pready_reg;
    assign pslverr       = pslverr_reg;
    assign sdata_out_pin = sdo_reg;
    assign sdata_out_oe  = sdo_oe_reg;
    assign audio_out     = audio_reg;
    assign audio_valid   = audio_valid_reg;
    assign audio_defer   = audio_defer_reg;

    // Checks
    property p_word_16;
        @(posedge pclk) disable iff (!presetn)
        (cap_bit && in_last && insz[aud_sel] == INSZ_16) |=>
            (audio_valid && audio_out.word[7:0] == 8'h00);
    endproperty
    a_word_16: assert property (p_word_16) else $error("16-bit word not padded");

    property p_word_24;
        @(posedge pclk) disable iff (!presetn)
        (cap_bit && in_last && insz[aud_sel] == INSZ_24) |=>
            (audio_valid && audio_out.word == $past(shift_next));
    endproperty
    a_word_24: assert property (p_word_24) else $error("24-bit word wrong");

    property p_skip_len;
        @(posedge pclk) disable iff (!presetn)
        (in_busy && skip[in_place]) |-> (in_lens[5*int'(in_place) +: 5] == LEN_8);
    endproperty
    a_skip_len: assert property (p_skip_len) else $error("skip length not eight");

    property p_skip_no_cap;
        @(posedge pclk) disable iff (!presetn)
        (rise_tick && in_busy && skip[in_place]) |-> !cap_bit;
    endproperty
    a_skip_no_cap: assert property (p_skip_no_cap) else $error("skipped bits kept");

    property p_from_left_two;
        @(posedge pclk) disable iff (!presetn)
        (skip[0] && skip[1] && !skip[2]) |-> (aud_sel == 2'h2);
    endproperty
    a_from_left_two: assert property (p_from_left_two) else $error("audio not from left two");

    property p_defer;
        @(posedge pclk) disable iff (!presetn)
        (frame_start && (&skip)) |=> (audio_defer ##1 !audio_defer);
    endproperty
    a_defer: assert property (p_defer) else $error("defer pulse missing");

    property p_volt_msb;
        @(posedge pclk) disable iff (!presetn)
        (fall_tick && out_busy && out_code == SNS_VOLT && out_cnt == 5'h00) |=>
            (sdata_out_oe && sdata_out_pin == snap_reg.voltage[15]);
    endproperty
    a_volt_msb: assert property (p_volt_msb) else $error("voltage msb wrong");

    property p_eight_len;
        @(posedge pclk) disable iff (!presetn)
        (out_busy && (out_code == SNS_BATT || out_code == SNS_CTRL ||
                      out_code == SNS_STATUS)) |->
            (out_lens[5*int'(out_place) +: 5] == LEN_8);
    endproperty
    a_eight_len: assert property (p_eight_len) else $error("8-bit sense length wrong");

    property p_blank;
        @(posedge pclk) disable iff (!presetn)
        (fall_tick && out_busy && out_code == SNS_BLANK) |=> (sdata_out_oe && !sdata_out_pin);
    endproperty
    a_blank: assert property (p_blank) else $error("blank bit driven high");

    property p_reset_vals;
        @(posedge pclk) disable iff (!presetn)
        first_reg |-> (insz[1] == RST_INSZ_RIGHT_ONE && sns[1] == RST_SNS_RIGHT_ONE &&
                       insz[2] == RST_INSZ_LEFT_TWO && sns[2] == RST_SNS_LEFT_TWO);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_from_right_one;
        @(posedge pclk) disable iff (!presetn)
        (skip[0] && !skip[1]) |-> (aud_sel == 2'h1);
    endproperty
    a_from_right_one: assert property (p_from_right_one) else $error("audio not from right one");

    property p_oe_span;
        @(posedge pclk) disable iff (!presetn)
        (fall_tick && !out_busy) |=> !sdata_out_oe;
    endproperty
    a_oe_span: assert property (p_oe_span) else $error("pin driven past placements");

endmodule

`default_nettype wire

// ### testbench/ssp_host_model.sv
`default_nettype none

module ssp_host_model
    import ssp_pkg::*;
#(
    parameter int HALF = 6
)
(
    input  wire logic pclk,
    input  wire logic sdata_out_pin,
    output logic      bclk_pin,
    output logic      fsync_pin,
    output logic      sdata_in_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        bclk_pin     = 1'h0;
        fsync_pin    = 1'h0;
        sdata_in_pin = 1'h0;
    end

    task automatic run_frame(input logic [47:0] tx, output logic [47:0] rx);
        int k;
        rx = '0;
        repeat (HALF) @(posedge pclk);
        bclk_pin <= 1'h1;
        repeat (HALF) @(posedge pclk);
        bclk_pin     <= 1'h0;
        fsync_pin    <= 1'h1;
        sdata_in_pin <= tx[47];
        for (k = 0; k < 49; k++)
        begin
            repeat (HALF) @(posedge pclk);
            bclk_pin <= 1'h1;
            if (k > 0)
                rx[48-k] = sdata_out_pin;
            repeat (HALF) @(posedge pclk);
            bclk_pin     <= 1'h0;
            fsync_pin    <= 1'h0;
            sdata_in_pin <= (k < 47) ? tx[46-k] : ~sdata_in_pin;
        end
    endtask
endmodule

`default_nettype wire

// ### testbench/ssp_ctrl_tb.sv
`default_nettype none

module ssp_ctrl_tb
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam ssp_sense_t SENSE = '{voltage: 16'h8e31, current: 16'h4c7a, battery: 8'hb5,
                                     control: 8'h69, status: 8'hd2, slot_id: 3'h5};
    localparam logic [47:0] TX0 = 48'ha5c3_1e96_7b2d;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              bclk;
    logic              fsync;
    logic              sdi;
    logic              sdo;
    logic              sdo_oe;
    logic              audio_valid;
    logic              audio_defer;
    ssp_sense_t        sense;
    ssp_audio_t        audio;
    ssp_audio_t        last_audio;
    logic [47:0]       rx;
    logic [31:0]       r;
    logic              e;
    int                n_valid;
    int                n_defer;
    int                frames;
    int                cycles;
    int                miscompares;
    int                checks_done;

    ssp_ctrl ssp_ctrl_i (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .bclk_pin      (bclk),
        .fsync_pin     (fsync),
        .sdata_in_pin  (sdi),
        .sdata_out_pin (sdo),
        .sdata_out_oe  (sdo_oe),
        .sense_in      (sense),
        .audio_out     (audio),
        .audio_valid   (audio_valid),
        .audio_defer   (audio_defer)
    );

    ssp_host_model ssp_host_model_i (
        .pclk          (pclk),
        .sdata_out_pin (sdo),
        .bclk_pin      (bclk),
        .fsync_pin     (fsync),
        .sdata_in_pin  (sdi)
    );

    always #25 pclk = ~pclk;

    task give_verdict;
        $display("Checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (audio_valid === 1'h1)
        begin
            n_valid++;
            last_audio = audio;
        end
        if (audio_defer === 1'h1)
            n_defer++;
        if (cycles == 30000)
        begin
            miscompares++;
            $display("ERROR run_cycles expected below %0d seen %0d", 30000, cycles);
            give_verdict();
        end
    end

    task chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        if (n == 50)
            chk("pready_wait", 48'h1, 48'h0);
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'h0, a, 32'h0, r, e);
        chk("read_data", {16'h0, exp}, {16'h0, r});
        chk("read_error", {47'h0, err}, {47'h0, e});
    endtask

    task cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
        apb(1'h1, 8'h18, {24'h0, c0}, r, e);
        apb(1'h1, 8'h1c, {24'h0, c1}, r, e);
        apb(1'h1, 8'h20, {24'h0, c2}, r, e);
    endtask

    function automatic logic [15:0] sval(input logic [2:0] c, input logic ph);
        case (c)
            3'h0: return SENSE.voltage;
            3'h1: return SENSE.current;
            3'h4: return ph ? SENSE.current : SENSE.voltage;
            3'h2: return {SENSE.battery, 8'h0};
            3'h3: return {SENSE.control, 8'h0};
            3'h5: return {SENSE.status, 8'h0};
            3'h6: return {ph, 4'h0, SENSE.slot_id, 8'h0};
            default: return 16'h0;
        endcase
    endfunction

    task frame(input logic [47:0] tx, input logic [7:0] c0, input logic [7:0] c1,
               input logic [7:0] c2);
        logic [47:0] es;
        logic [47:0] care;
        logic [23:0] ea;
        logic [1:0]  ep;
        logic        dfr;
        logic [7:0]  c [3];
        logic [15:0] v;
        int          off;
        int          p;
        c = '{c0, c1, c2};
        frames++;
        es = '0;
        care = '0;
        off = 0;
        for (p = 0; p < 3; p++)
        begin
            v = sval(c[p][2:0], frames[0]);
            if (c[p][2:0] inside {3'h0, 3'h1, 3'h4})
            begin
                es |= {v, 32'h0} >> off;
                care |= {16'hffff, 32'h0} >> off;
                off += 16;
            end
            else
            begin
                care |= {8'hff, 40'h0} >> off;
                es |= {v[15:8], 40'h0} >> off;
                off += 8;
            end
        end
        es &= care;
        dfr = 1'h1;
        ea = '0;
        ep = '0;
        off = 0;
        for (p = 0; p < 3; p++)
        begin
            if (dfr && c[p][5])
                off += 8;
            else if (dfr)
            begin
                dfr = 1'h0;
                ep = p[1:0];
                ea = c[p][4] ? {tx[47-off -: 16], 8'h0} : tx[47-off -: 24];
            end
        end
        n_valid = 0;
        n_defer = 0;
        ssp_host_model_i.run_frame(tx, rx);
        repeat (4) @(posedge pclk);
        chk("sense_bits", es, rx & care);
        chk("sense_release", 48'h0, {47'h0, sdo_oe});
        chk("audio_count", {47'h0, ~dfr}, 48'(n_valid));
        chk("defer_count", {47'h0, dfr}, 48'(n_defer));
        if (!dfr)
            chk("audio_word", {22'h0, ea, ep}, {22'h0, last_audio});
        $display("frame %0d done", frames);
    endtask

    initial
    begin
        pclk = 1'h0;
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        sense = SENSE;
        cycles = 0;
        frames = 0;
        miscompares = 0;
        checks_done = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        repeat (3) @(posedge pclk);
        reg_chk(8'h18, 32'h01, 1'h0);
        reg_chk(8'h1c, 32'h20, 1'h0);
        reg_chk(8'h20, 32'h32, 1'h0);
        reg_chk(8'h24, 32'h0, 1'h1);
        reg_chk(8'h1d, 32'h0, 1'h1);
        apb(1'h1, 8'h1c, 32'hffff_ffff, r, e);
        reg_chk(8'h1c, 32'hff, 1'h0);
        apb(1'h1, 8'h24, 32'h55, r, e);
        reg_chk(8'h18, 32'h01, 1'h0);
        apb(1'h1, 8'h1c, 32'h20, r, e);
        $display("registers done");
        frame(TX0, 8'h01, 8'h20, 8'h32);
        cfg(8'h27, 8'h13, 8'h25);
        frame(TX0 ^ 48'h1111_2222_3333, 8'h27, 8'h13, 8'h25);
        cfg(8'h36, 8'h34, 8'h00);
        frame(TX0 ^ 48'h4444_5555_6666, 8'h36, 8'h34, 8'h00);
        frame(TX0 ^ 48'h7777_8888_9999, 8'h36, 8'h34, 8'h00);
        cfg(8'h20, 8'h31, 8'h32);
        frame(TX0, 8'h20, 8'h31, 8'h32);
        give_verdict();
    end
endmodule

`default_nettype wire
